// ===== verilog/aao_pkg.sv
// aao_pkg: shared constants and types for the accumulator add/and slice
// assumes an 8-bit data path and a decoder that issues one op per request
package aao_pkg;
   localparam int unsigned DATA_W   = 8;
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam int unsigned CARRY_B  = 7;   // carry out of bit 7
   localparam int unsigned AUX_B    = 3;   // aux carry out of bit 3
   // flag vector positions
   localparam int unsigned FLG_C    = 0;
   localparam int unsigned FLG_AC   = 1;
   localparam int unsigned FLG_Z    = 2;
   localparam int unsigned FLG_OV   = 3;
   localparam logic [3:0]  FLG_RST  = 4'h0;

   // operation codes presented by the decoder
   typedef enum logic [2:0] {
      AAO_NOP,
      AAO_ADD_ACC_TO_MEMORY,
      AAO_AND_MEM_TO_ACC,
      AAO_AND_IMM_TO_ACC,
      AAO_AND_ACC_TO_MEMORY
   } aao_op_t;

   typedef enum logic [1:0] {
      AAO_IDLE,
      AAO_READ,
      AAO_EXEC
   } aao_state_t;
endpackage

// ===== verilog/aao_alu.sv
// aao_alu: combinational add and and with flag outputs
// assumes operands are stable for the whole evaluation cycle
`timescale 1ns/1ps
module aao_alu
   import aao_pkg::*;
(
   // operands
   input  wire logic [7:0] opA,
   input  wire logic [7:0] opB,
   input  wire logic       doAdd,
   // results
   output logic [7:0]      result,
   output logic [3:0]      flags
);
   logic [4:0] lowSum;
   logic [8:0] fullSum;

   // add with carry chain split at the nibble for aux carry
   always_comb begin
      lowSum  = {1'b0, opA[AUX_B:0]} + {1'b0, opB[AUX_B:0]};
      fullSum = {1'b0, opA} + {1'b0, opB};
      flags   = FLG_RST;
      if (doAdd) begin
         result           = fullSum[CARRY_B:0];
         flags[FLG_C]     = fullSum[CARRY_B+1];
         flags[FLG_AC]    = lowSum[AUX_B+1];
         flags[FLG_OV]    = (opA[CARRY_B] == opB[CARRY_B]) &&
                            (result[CARRY_B] != opA[CARRY_B]);
      end else begin
         result = opA & opB;
      end
      flags[FLG_Z] = (result == 8'h00);
   end
endmodule // aao_alu

// ===== verilog/aao_datapath.sv
// aao_datapath: accumulator slice for add-to-memory and three and forms
// assumes a synchronous data memory with one cycle read latency
`timescale 1ns/1ps
module aao_datapath
   import aao_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // request from the decoder
   input  wire logic       opValid,
   input  aao_op_t         opCode,
   input  wire logic [7:0] memAddr,
   input  wire logic [7:0] immData,
   output logic            opReady,
   output logic            opDone,
   // accumulator write from the rest of the core
   input  wire logic       accLoad,
   input  wire logic [7:0] accLoadData,
   // data memory port
   output logic            memRead,
   output logic            memWrite,
   output logic [7:0]      memAddrOut,
   output logic [7:0]      memWriteData,
   input  wire logic [7:0] memReadData,
   // architectural state
   output logic [7:0]      accumulatorReg,
   output logic            overflowFlag,
   output logic            zeroFlag,
   output logic            auxCarryFlag,
   output logic            carryFlag
);
   aao_state_t state, next_state;
   aao_op_t    curOp, next_curOp;
   logic [7:0] curImm, next_curImm;
   logic [7:0] next_accumulatorReg, next_memWriteData, next_memAddrOut;
   logic       next_overflowFlag, next_zeroFlag;
   logic       next_auxCarryFlag, next_carryFlag;
   logic       next_memRead, next_memWrite, next_opDone;
   logic [7:0] aluB, aluResult;
   logic [3:0] aluFlags;

   // operand b is the immediate only for the immediate and
   assign aluB = (curOp == AAO_AND_IMM_TO_ACC) ? curImm : memReadData;

   aao_alu u_alu (
      .opA    (accumulatorReg),
      .opB    (aluB),
      .doAdd  (curOp == AAO_ADD_ACC_TO_MEMORY),
      .result (aluResult),
      .flags  (aluFlags)
   );

   // accepting only in idle keeps one op in flight
   assign opReady = (state == AAO_IDLE);

   // next state and datapath updates
   always_comb begin
      next_state          = state;
      next_curOp          = curOp;
      next_curImm         = curImm;
      next_accumulatorReg = accumulatorReg;
      next_overflowFlag   = overflowFlag;
      next_zeroFlag       = zeroFlag;
      next_auxCarryFlag   = auxCarryFlag;
      next_carryFlag      = carryFlag;
      next_memAddrOut     = memAddrOut;
      next_memWriteData   = memWriteData;
      next_memRead        = 1'b0;
      next_memWrite       = 1'b0;
      next_opDone         = 1'b0;
      unique case (state)
         AAO_IDLE: begin
            // other instructions write the accumulator only between ops
            if (accLoad) begin
               next_accumulatorReg = accLoadData;
            end
            if (opValid && opCode != AAO_NOP) begin
               next_curOp      = opCode;
               next_curImm     = immData;
               next_memAddrOut = memAddr;
               // immediate form needs no memory read
               if (opCode == AAO_AND_IMM_TO_ACC) begin
                  next_state = AAO_EXEC;
               end else begin
                  next_memRead = 1'b1;
                  next_state   = AAO_READ;
               end
            end
         end
         AAO_READ: begin
            next_state = AAO_EXEC; // read data valid next cycle
         end
         AAO_EXEC: begin
            next_state    = AAO_IDLE;
            next_opDone   = 1'b1;
            next_zeroFlag = aluFlags[FLG_Z];
            unique case (curOp)
               AAO_ADD_ACC_TO_MEMORY: begin
                  next_memWrite     = 1'b1;
                  next_memWriteData = aluResult;
                  next_overflowFlag = aluFlags[FLG_OV];
                  next_auxCarryFlag = aluFlags[FLG_AC];
                  next_carryFlag    = aluFlags[FLG_C];
               end
               AAO_AND_MEM_TO_ACC,
               AAO_AND_IMM_TO_ACC: begin
                  next_accumulatorReg = aluResult;
               end
               AAO_AND_ACC_TO_MEMORY: begin
                  next_memWrite     = 1'b1;
                  next_memWriteData = aluResult;
               end
               default: begin
                  next_opDone = 1'b0;
               end
            endcase
         end
         default: next_state = AAO_IDLE;
      endcase
   end

   // registers only
   always_ff @(posedge clk) begin
      if (reset) begin
         state          <= AAO_IDLE;
         curOp          <= AAO_NOP;
         curImm         <= 8'h00;
         accumulatorReg <= ACC_RST;
         overflowFlag   <= 1'b0;
         zeroFlag       <= 1'b0;
         auxCarryFlag   <= 1'b0;
         carryFlag      <= 1'b0;
         memAddrOut     <= 8'h00;
         memWriteData   <= 8'h00;
         memRead        <= 1'b0;
         memWrite       <= 1'b0;
         opDone         <= 1'b0;
      end else begin
         state          <= next_state;
         curOp          <= next_curOp;
         curImm         <= next_curImm;
         accumulatorReg <= next_accumulatorReg;
         overflowFlag   <= next_overflowFlag;
         zeroFlag       <= next_zeroFlag;
         auxCarryFlag   <= next_auxCarryFlag;
         carryFlag      <= next_carryFlag;
         memAddrOut     <= next_memAddrOut;
         memWriteData   <= next_memWriteData;
         memRead        <= next_memRead;
         memWrite       <= next_memWrite;
         opDone         <= next_opDone;
      end
   end

   // checks
   a_add_keeps_acc: assert property (@(posedge clk) disable iff (reset)
      memWrite && curOp == AAO_ADD_ACC_TO_MEMORY
      |-> accumulatorReg == $past(accumulatorReg))
      else $error("add changed accumulator");
   a_add_sum_val: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_ADD_ACC_TO_MEMORY
      |=> memWrite && memWriteData ==
          8'($past(accumulatorReg) + $past(memReadData)))
      else $error("add sum wrong");
   a_add_carry_out: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_ADD_ACC_TO_MEMORY
      |=> carryFlag == (9'({1'b0, $past(accumulatorReg)})
          + 9'({1'b0, $past(memReadData)}) > 9'h0FF))
      else $error("carry wrong");
   // carry, aux and overflow checks work from the operands, overflow also from the written sum, zero from the result; none from the alu flag outputs
   a_add_ov_flag: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_ADD_ACC_TO_MEMORY
      |=> overflowFlag == ($past(accumulatorReg[7]) == $past(memReadData[7])
          && memWriteData[7] != $past(accumulatorReg[7])))
      else $error("overflow wrong");
   a_add_aux_flag: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_ADD_ACC_TO_MEMORY
      |=> auxCarryFlag == (5'($past(accumulatorReg[3:0]))
          + 5'($past(memReadData[3:0])) > 5'h0F))
      else $error("aux carry wrong");
   a_and_mem_acc: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_AND_MEM_TO_ACC
      |=> accumulatorReg == ($past(accumulatorReg) & $past(memReadData))
          && !memWrite && carryFlag == $past(carryFlag))
      else $error("and from memory wrong");
   a_and_imm_acc: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_AND_IMM_TO_ACC
      |=> accumulatorReg == ($past(accumulatorReg) & $past(curImm))
          && overflowFlag == $past(overflowFlag))
      else $error("and immediate wrong");
   a_acc_no_write: assert property (@(posedge clk) disable iff (reset)
      (curOp == AAO_AND_MEM_TO_ACC || curOp == AAO_AND_IMM_TO_ACC)
      |-> !memWrite)
      else $error("and to acc wrote memory");
   a_and_to_mem: assert property (@(posedge clk) disable iff (reset)
      state == AAO_EXEC && curOp == AAO_AND_ACC_TO_MEMORY
      |=> memWrite && memWriteData ==
          ($past(accumulatorReg) & $past(memReadData)))
      else $error("and to memory wrong");
   a_zero_flag: assert property (@(posedge clk) disable iff (reset)
      opDone |-> zeroFlag == ((curOp == AAO_ADD_ACC_TO_MEMORY ||
          curOp == AAO_AND_ACC_TO_MEMORY) ? memWriteData == 8'h00
          : accumulatorReg == 8'h00))
      else $error("zero flag wrong");
   c_and_acc: cover property (@(posedge clk)
      opDone && curOp == AAO_AND_MEM_TO_ACC && !zeroFlag);
   c_add: cover property (@(posedge clk)
      opDone && curOp == AAO_ADD_ACC_TO_MEMORY && carryFlag);
   c_and_imm: cover property (@(posedge clk)
      opDone && curOp == AAO_AND_IMM_TO_ACC && zeroFlag);
   c_and_mem: cover property (@(posedge clk)
      opDone && curOp == AAO_AND_ACC_TO_MEMORY);
endmodule // aao_datapath

// ===== verification/tb.sv
// tb: self-checking bench for the accumulator add/and slice
// assumes a one-cycle sync ram, modelled here, behind the memory port
`timescale 1ns/1ps
module tb;
   import aao_pkg::*;
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
      logic [7:0] acc;
      logic [3:0] flg;
   } aao_exp_t;

   // stimulus and design outputs
   logic       clk = 1'b0, reset = 1'b1, opValid = 1'b0, accLoad = 1'b0;
   logic [7:0] accLoadData = 8'h00;
   aao_op_t    opCode = AAO_NOP;
   logic [7:0] memAddr = 8'h00, immData = 8'h00, memReadData = 8'h00;
   logic       opReady, opDone, memRead, memWrite;
   logic [7:0] memAddrOut, memWriteData, accumulatorReg;
   logic       overflowFlag, zeroFlag, auxCarryFlag, carryFlag;
   logic [3:0] obsFlg;
   // ram, its model twin, and the queue of expected results
   logic [7:0] mem [256];
   logic [7:0] expMem [256];
   logic [7:0] modelAcc = ACC_RST;
   logic [3:0] modelFlg = FLG_RST;
   aao_exp_t   expQ [$];
   int         mismatches = 0, testsRun = 0, cycles = 0;

   aao_datapath dut (.clk(clk), .reset(reset), .opValid(opValid),
      .opCode(opCode), .memAddr(memAddr), .immData(immData),
      .opReady(opReady), .opDone(opDone), .memRead(memRead),
      .accLoad(accLoad), .accLoadData(accLoadData),
      .memWrite(memWrite), .memAddrOut(memAddrOut),
      .memWriteData(memWriteData), .memReadData(memReadData),
      .accumulatorReg(accumulatorReg), .overflowFlag(overflowFlag),
      .zeroFlag(zeroFlag), .auxCarryFlag(auxCarryFlag),
      .carryFlag(carryFlag));

   always #10 clk = ~clk;
   always_comb begin
      obsFlg         = 4'h0;
      obsFlg[FLG_C]  = carryFlag;
      obsFlg[FLG_AC] = auxCarryFlag;
      obsFlg[FLG_Z]  = zeroFlag;
      obsFlg[FLG_OV] = overflowFlag;
   end

   task automatic chk(string name, logic [7:0] e, logic [7:0] g);
      testsRun++;
      if (e !== g) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic stop_test();
      if (mismatches == 0 && testsRun > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ram: data only in the cycle after the read, toggling otherwise
   // so a sample taken a cycle late never matches by luck
   always @(posedge clk) begin
      if (memRead) memReadData <= mem[memAddrOut];
      else memReadData <= ~memReadData;
      if (memWrite) mem[memAddrOut] <= memWriteData;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   // watcher: oldest note checked against each finished op
   always @(negedge clk) begin
      aao_exp_t e;
      if (!reset && opDone) begin
         if (expQ.size() == 0) chk("unexpected done", 8'h00, 8'h01);
         else begin
            e = expQ.pop_front();
            chk("memWrite", {7'h00, e.wr}, {7'h00, memWrite});
            if (e.wr) chk("memWriteData", e.data, memWriteData);
            chk("acc", e.acc, accumulatorReg);
            chk("flags", {4'h0, e.flg}, {4'h0, obsFlg});
         end
      end else if (!reset && memWrite) chk("stray write", 8'h00, 8'h01);
   end

   // driver: holds the request until taken, notes the expected outcome
   task automatic issue(aao_op_t op, logic [7:0] a, logic [7:0] im);
      logic [8:0] s;
      aao_exp_t   e;
      @(negedge clk);
      opValid = 1'b1;
      opCode  = op;
      memAddr = a;
      immData = im;
      while (opReady !== 1'b1) @(negedge clk);
      e = '0;
      s = {1'b0, expMem[a]} + {1'b0, modelAcc};
      case (op)
         AAO_ADD_ACC_TO_MEMORY: begin
            modelFlg[FLG_C]  = s[8];
            modelFlg[FLG_AC] = ({1'b0, modelAcc[3:0]}
                               + {1'b0, expMem[a][3:0]}) > 5'h0F;
            modelFlg[FLG_OV] = (modelAcc[7] == expMem[a][7])
                               && (s[7] != modelAcc[7]);
            modelFlg[FLG_Z]  = (s[7:0] == 8'h00);
            e.wr = 1'b1;
            e.data = s[7:0];
         end
         AAO_AND_MEM_TO_ACC: modelAcc = modelAcc & expMem[a];
         AAO_AND_IMM_TO_ACC: modelAcc = modelAcc & im;
         default: begin
            e.wr = 1'b1;
            e.data = expMem[a] & modelAcc;
            modelFlg[FLG_Z] = (e.data == 8'h00);
         end
      endcase
      if (op == AAO_AND_MEM_TO_ACC || op == AAO_AND_IMM_TO_ACC)
         modelFlg[FLG_Z] = (modelAcc == 8'h00);
      if (e.wr) expMem[a] = e.data;
      e.acc = modelAcc;
      e.flg = modelFlg;
      expQ.push_back(e);
   endtask

   // accumulator write between ops, so ands and adds see nonzero values
   task automatic load_acc(logic [7:0] v);
      @(negedge clk);
      opValid = 1'b0;
      while (opReady !== 1'b1) @(negedge clk);
      accLoad     = 1'b1;
      accLoadData = v;
      modelAcc    = v;
      @(negedge clk);
      accLoad = 1'b0;
   endtask

   // main sequence: reset, every op once, a refused nop, random mix
   initial begin
      void'($urandom(4));
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($urandom);
         expMem[i] = mem[i];
      end
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      chk("reset acc", ACC_RST, accumulatorReg);
      chk("reset flags", {4'h0, FLG_RST}, {4'h0, obsFlg});
      load_acc(8'hC7);
      for (int k = 1; k <= 4; k++) issue(aao_op_t'(k), 8'h05, 8'hFF);
      @(negedge clk);
      opCode = AAO_NOP;
      while (opReady !== 1'b1) @(negedge clk);
      repeat (6) begin
         @(negedge clk);
         chk("nop refused", 8'h01, {7'h00, opReady});
      end
      for (int n = 0; n < 200; n++) begin
         if ($urandom % 3 == 0) load_acc(8'($urandom));
         issue(aao_op_t'(3'(1 + $urandom % 4)), 8'($urandom % 8),
               8'($urandom));
      end
      @(negedge clk);
      opValid = 1'b0;
      repeat (8) @(negedge clk);
      chk("pending notes", 8'h00, 8'(expQ.size()));
      stop_test();
   end
endmodule // tb
